// file: rtl/psc_defines.svh
// Register offsets, field positions, reset values and timing counts for pulse skip control
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PSC_ADDR_OUTCTL     12'h000
`define PSC_ADDR_DUTY_FIRST 12'h004
`define PSC_ADDR_GDUTY      12'h01C
`define PSC_ADDR_GSEL       12'h020
`define PSC_ADDR_INSEL      12'h024
`define PSC_ADDR_STATUS     12'h028

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSC_OUTCTL_ON_LSB   0
`define PSC_OUTCTL_PSF_LSB  8
`define PSC_STAT_CH_LSB     0
`define PSC_STAT_IN_LSB     8
`define PSC_STAT_FAIL_BIT   12
`define PSC_STAT_CLKF_BIT   13
`define PSC_STAT_SKIP_LSB   16

// ----------------------------------------------------------------
// Reset values and duty codes
// ----------------------------------------------------------------
`define PSC_RST_ON          6'h00
`define PSC_RST_PSF         5'h00
`define PSC_RST_DUTY        8'h00
`define PSC_RST_GSEL        6'h00
`define PSC_RST_INSEL       8'h00
`define PSC_DUTY_FULL       8'hFF
`define PSC_DUTY_REDUCED    8'hF7
`define PSC_DUTY_SKIP_LOW   8'hF8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSC_CLK_PERIOD_NS   10
`define PSC_DEGLITCH_NS     10000
`define PSC_DEGLITCH_CYCLES ((`PSC_DEGLITCH_NS + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS)
`define PSC_CLK_FAIL_NS     80000
`define PSC_CLK_FAIL_CYCLES (`PSC_CLK_FAIL_NS / `PSC_CLK_PERIOD_NS)

`endif

// file: rtl/psc_pkg.sv
// Types shared by the pulse skip and input control design
package psc_pkg;

  typedef logic [7:0] psc_duty_t;

  typedef enum logic [1:0] {
    PSC_APB_IDLE = 2'b01,
    PSC_APB_RESP = 2'b10
  } psc_apb_state_t;

  typedef enum logic [1:0] {
    PSC_SEL_SERIAL      = 2'b00,
    PSC_SEL_INPUT       = 2'b01,
    PSC_SEL_INPUT_GATED = 2'b10,
    PSC_SEL_SERIAL_SWAP = 2'b11
  } psc_insel_t;

endpackage : psc_pkg

// file: rtl/psc_filt_if.sv
// Interface between the control logic and the direct input deglitch filter
`timescale 1ns/1ps

interface psc_filt_if #(
  parameter int N = 4
);
  logic [N-1:0] raw;
  logic [N-1:0] filtered;

  modport filt (input raw, output filtered);
  modport user (output raw, input filtered);
endinterface : psc_filt_if

// file: rtl/psc_deglitch.sv
// Synchroniser and deglitch filter for the direct control inputs
`timescale 1ns/1ps
`include "psc_defines.svh"

module psc_deglitch
  import psc_pkg::*;
#(
  parameter int N      = 4,
  parameter int CYCLES = `PSC_DEGLITCH_CYCLES
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Raw pins in, filtered levels out
  psc_filt_if.filt  bus
);

  localparam int CW = $clog2(CYCLES + 1);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_in
      logic          sync1_q;
      logic          sync2_q;
      logic          filt_q;
      logic [CW-1:0] cnt_q;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q <= 1'b0;
          sync2_q <= 1'b0;
        end else begin
          sync1_q <= bus.raw[i];
          sync2_q <= sync1_q;
        end
      end

      // New level is taken only after it held for the full window
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt_q <= 1'b0;
          cnt_q  <= '0;
        end else if (sync2_q == filt_q) begin
          cnt_q  <= '0;
        end else if (cnt_q == CW'(CYCLES - 1)) begin
          filt_q <= sync2_q;
          cnt_q  <= '0;
        end else begin
          cnt_q  <= cnt_q + 1'b1;
        end
      end

      assign bus.filtered[i] = filt_q;
    end
  endgenerate

endmodule : psc_deglitch

// file: rtl/psc_top.sv
// Pulse skip PWM extension and per-channel on/off source selection with APB registers
// ----------------------------------------------------------------
// How it works
// - Codes F8..FE interpolated over eight states
// - Codes 00..F7 never interpolated
// - Interpolation only in Normal mode
// - Skip enable separate per internal channel
// - External switch output never skips
// - Skip bits share register with on bits
// - Skip bit zero disables; reset zero
// - Skip bit one enables skipping
// - Four direct inputs wake and control
// - Two-bit field selects input effect
// - Direct inputs deglitched before use
// - Channels 1-4 from on bit or input
// - Channels 5-6 only from on bits
// - Rising channel-on of 1-5 starts overcurrent window
// - Fail: 1-4 follow inputs, 5-6 off
// - Fail: input rising starts overcurrent window
// - Fail mode: plain on/off, no PWM
// - On bit switches channel, and window for 1-5
// - Global duty keeps own skip setting
// ----------------------------------------------------------------
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "psc_defines.svh"

module psc_top
  import psc_pkg::*;
#(
  parameter int NCH             = 6,
  parameter int NIN             = 4,
  parameter int DEGLITCH_CYCLES = `PSC_DEGLITCH_CYCLES,
  parameter int CLK_FAIL_CYCLES = `PSC_CLK_FAIL_CYCLES
) (
  // Clock and reset
  input  wire  logic             pclk,
  input  wire  logic             presetn,
  // APB slave
  input  wire  logic             psel,
  input  wire  logic             penable,
  input  wire  logic             pwrite,
  input  wire  logic [11:0]      paddr,
  input  wire  logic [31:0]      pwdata,
  output logic       [31:0]      prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Device state and pins
  input  wire  logic             fail_mode,
  input  wire  logic             pwm_clk_in,
  input  wire  logic [NIN-1:0]   direct_control_input,
  // Channel controls
  output logic       [NCH-1:0]   channel_on_signal,
  output logic       [NCH-2:0]   channel_drive,
  output logic                   external_switch_output,
  output logic       [NCH-2:0]   oc_window_start,
  output logic                   wake_request
);

  localparam int CFW = $clog2(CLK_FAIL_CYCLES + 1);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  psc_apb_state_t     apb_state_q;
  logic [NCH-1:0]     on_q;
  logic [NCH-2:0]     pulse_skip_enable_q;
  psc_duty_t          duty_q [NCH];
  psc_duty_t          gduty_q;
  logic [NCH-1:0]     gsel_q;
  logic [2*NIN-1:0]   insel_q;
  logic [31:0]        rdata_d;
  logic               mapped;
  logic               wr_en;

  assign wr_en  = psel && penable && pwrite && pready && (apb_state_q == PSC_APB_RESP);
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `PSC_ADDR_STATUS);

  // No wait state: answer registered at the end of setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_q <= PSC_APB_IDLE;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
    end else begin
      unique case (apb_state_q)
        PSC_APB_IDLE: begin
          if (psel && !penable) begin
            apb_state_q <= PSC_APB_RESP;
            pready      <= 1'b1;
            pslverr     <= !mapped;
            prdata      <= pwrite ? 32'h0000_0000 : rdata_d;
          end
        end
        PSC_APB_RESP: begin
          apb_state_q <= PSC_APB_IDLE;
          pready      <= 1'b0;
          pslverr     <= 1'b0;
          prdata      <= 32'h0000_0000;
        end
        default: begin
          apb_state_q <= PSC_APB_IDLE;
          pready      <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q                <= `PSC_RST_ON;
      pulse_skip_enable_q <= `PSC_RST_PSF;
    end else if (wr_en && paddr == `PSC_ADDR_OUTCTL) begin
      on_q                <= pwdata[`PSC_OUTCTL_ON_LSB +: NCH];
      pulse_skip_enable_q <= pwdata[`PSC_OUTCTL_PSF_LSB +: NCH-1];
    end
  end

  genvar k;
  generate
    for (k = 0; k < NCH; k++) begin : g_duty
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          duty_q[k] <= `PSC_RST_DUTY;
        end else if (wr_en && paddr == (`PSC_ADDR_DUTY_FIRST + 12'(4 * k))) begin
          duty_q[k] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gduty_q <= `PSC_RST_DUTY;
      gsel_q  <= `PSC_RST_GSEL;
      insel_q <= `PSC_RST_INSEL;
    end else if (wr_en) begin
      if (paddr == `PSC_ADDR_GDUTY) begin
        gduty_q <= pwdata[7:0];
      end
      if (paddr == `PSC_ADDR_GSEL) begin
        gsel_q <= pwdata[NCH-1:0];
      end
      if (paddr == `PSC_ADDR_INSEL) begin
        insel_q <= pwdata[2*NIN-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Direct inputs
  // ----------------------------------------------------------------
  psc_filt_if #(.N(NIN)) filt_bus ();

  assign filt_bus.raw = direct_control_input;

  psc_deglitch #(
    .N      (NIN),
    .CYCLES (DEGLITCH_CYCLES)
  ) u_deglitch (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (filt_bus)
  );

  logic [NIN-1:0] filtered_direct_input;
  logic [NIN-1:0] filtered_prev_q;

  assign filtered_direct_input = filt_bus.filtered;

  // Any active input asks the device to wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request    <= 1'b0;
      filtered_prev_q <= '0;
    end else begin
      wake_request    <= |filtered_direct_input;
      filtered_prev_q <= filtered_direct_input;
    end
  end

  // ----------------------------------------------------------------
  // Reference PWM clock
  // ----------------------------------------------------------------
  logic            pclk_in_s1_q;
  logic            pclk_in_s2_q;
  logic            pclk_in_s3_q;
  logic            pwm_tick;
  logic [CFW-1:0]  fail_cnt_q;
  logic            clk_failed_q;
  psc_duty_t       pwm_cnt_q;
  logic [2:0]      skip_state_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pclk_in_s1_q <= 1'b0;
      pclk_in_s2_q <= 1'b0;
      pclk_in_s3_q <= 1'b0;
    end else begin
      pclk_in_s1_q <= pwm_clk_in;
      pclk_in_s2_q <= pclk_in_s1_q;
      pclk_in_s3_q <= pclk_in_s2_q;
    end
  end

  assign pwm_tick = pclk_in_s2_q && !pclk_in_s3_q;

  // Stalled reference clock falls back to full on rather than a frozen duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_cnt_q   <= '0;
      clk_failed_q <= 1'b1;
    end else if (pwm_tick) begin
      fail_cnt_q   <= '0;
      clk_failed_q <= 1'b0;
    end else if (fail_cnt_q == CFW'(CLK_FAIL_CYCLES - 1)) begin
      clk_failed_q <= 1'b1;
    end else begin
      fail_cnt_q   <= fail_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_q    <= 8'h00;
      skip_state_q <= 3'h0;
    end else if (pwm_tick) begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      if (pwm_cnt_q == `PSC_DUTY_FULL) begin
        skip_state_q <= skip_state_q + 3'h1;
      end
    end
  end

  // Bit-reversed state spreads the reduced periods evenly over the frame
  function automatic logic [2:0] psc_bitrev3(input logic [2:0] s);
    psc_bitrev3 = {s[0], s[1], s[2]};
  endfunction : psc_bitrev3

  logic [2:0] skip_rank;
  assign skip_rank = psc_bitrev3(skip_state_q);

  // ----------------------------------------------------------------
  // Channel control
  // ----------------------------------------------------------------
  logic [NCH-1:0] ch_d;
  logic [NCH-1:0] pwm_level;
  logic [NCH-2:0] oc_start_d;

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      psc_duty_t base;
      psc_duty_t code;
      psc_duty_t gap;
      logic      use_global;
      logic      skip_on;
      logic      in_range;

      if (i < NIN) begin : g_in
        psc_insel_t sel;
        assign sel = psc_insel_t'(insel_q[2*i +: 2]);
        // Fail mode follows the input; Normal uses on bit and selector
        assign ch_d[i] = fail_mode ? filtered_direct_input[i]
                       : on_q[i] && (sel == PSC_SEL_SERIAL || sel == PSC_SEL_SERIAL_SWAP
                                     || filtered_direct_input[i]);
        assign use_global = gsel_q[i] ^ (sel == PSC_SEL_SERIAL_SWAP
                                         && filtered_direct_input[i]);
      end else begin : g_serial
        assign ch_d[i] = fail_mode ? 1'b0 : on_q[i];
        assign use_global = gsel_q[i];
      end

      assign base = use_global ? gduty_q : duty_q[i];

      if (i < NCH - 1) begin : g_skip
        assign skip_on = pulse_skip_enable_q[i] && !fail_mode;
      end else begin : g_noskip
        assign skip_on = 1'b0;
      end

      // Only F8..FE are interpolated; low codes pass unchanged
      assign in_range = base >= `PSC_DUTY_SKIP_LOW && base != `PSC_DUTY_FULL;
      assign gap      = `PSC_DUTY_FULL - base;
      assign code     = (skip_on && in_range && {5'h00, skip_rank} < gap)
                        ? `PSC_DUTY_REDUCED : (skip_on && in_range)
                        ? `PSC_DUTY_FULL : base;
      assign pwm_level[i] = fail_mode || clk_failed_q || code == `PSC_DUTY_FULL
                            || pwm_cnt_q <= code;
    end

    for (i = 0; i < NCH - 1; i++) begin : g_oc
      if (i < NIN) begin : g_in
        assign oc_start_d[i] = fail_mode
                             ? (filtered_direct_input[i] && !filtered_prev_q[i])
                             : (ch_d[i] && !channel_on_signal[i]);
      end else begin : g_serial
        assign oc_start_d[i] = !fail_mode && ch_d[i] && !channel_on_signal[i];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_on_signal      <= '0;
      channel_drive          <= '0;
      external_switch_output <= 1'b0;
      oc_window_start        <= '0;
    end else begin
      channel_on_signal      <= ch_d;
      channel_drive          <= ch_d[NCH-2:0] & pwm_level[NCH-2:0];
      external_switch_output <= ch_d[NCH-1] & pwm_level[NCH-1];
      oc_window_start        <= oc_start_d;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (paddr == `PSC_ADDR_OUTCTL) begin
      rdata_d[`PSC_OUTCTL_ON_LSB +: NCH]    = on_q;
      rdata_d[`PSC_OUTCTL_PSF_LSB +: NCH-1] = pulse_skip_enable_q;
    end else if (paddr == `PSC_ADDR_GDUTY) begin
      rdata_d[7:0] = gduty_q;
    end else if (paddr == `PSC_ADDR_GSEL) begin
      rdata_d[NCH-1:0] = gsel_q;
    end else if (paddr == `PSC_ADDR_INSEL) begin
      rdata_d[2*NIN-1:0] = insel_q;
    end else if (paddr == `PSC_ADDR_STATUS) begin
      rdata_d[`PSC_STAT_CH_LSB +: NCH]  = channel_on_signal;
      rdata_d[`PSC_STAT_IN_LSB +: NIN]  = filtered_direct_input;
      rdata_d[`PSC_STAT_FAIL_BIT]       = fail_mode;
      rdata_d[`PSC_STAT_CLKF_BIT]       = clk_failed_q;
      rdata_d[`PSC_STAT_SKIP_LSB +: 3]  = skip_state_q;
    end else begin
      for (int d = 0; d < NCH; d++) begin
        if (paddr == (`PSC_ADDR_DUTY_FIRST + 12'(4 * d))) begin
          rdata_d[7:0] = duty_q[d];
        end
      end
    end
  end

endmodule : psc_top

// file: sim/psc_pwm_host.sv
// Reference PWM clock source standing in for the host side
`timescale 1ns/1ps

module psc_pwm_host #(
  parameter int HALF = 4
) (
  // Clock in, reference clock out
  input  wire logic pclk,
  output logic      pwm_clk_in
);
  int cnt;

  initial begin
    pwm_clk_in = 1'b0;
    cnt = 0;
  end

  // ----------------------------------------------------------------
  // Reference clock
  // ----------------------------------------------------------------
  // Period scaled down to keep runs short; still far above the sync depth
  always @(posedge pclk) begin
    cnt <= (cnt + 1) % HALF;
    if (cnt == HALF - 1) begin
      pwm_clk_in <= ~pwm_clk_in;
    end
  end
endmodule : psc_pwm_host

// file: sim/psc_top_props.sv
// Concurrent checks on the pulse skip and channel control ports
`timescale 1ns/1ps

module psc_top_props #(
  parameter int NCH = 6
) (
  // Clock and reset
  input wire logic           pclk,
  input wire logic           presetn,
  // APB
  input wire logic           psel,
  input wire logic           penable,
  input wire logic [11:0]    paddr,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // Mode and channels
  input wire logic           fail_mode,
  input wire logic [NCH-1:0] channel_on_signal,
  input wire logic [NCH-2:0] channel_drive,
  input wire logic           external_switch_output,
  input wire logic [NCH-2:0] oc_window_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  chk_ready_after_setup: assert property (psel && !penable |=> pready && penable)
    else $error("access phase without pready");
  chk_error_unmapped: assert property (
    pready |-> pslverr == (paddr > 12'h028 || paddr[1:0] != 2'b00))
    else $error("pslverr does not match address map");
  chk_idle_quiet: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data or error outside access");
  chk_fail_upper_off: assert property (
    $past(fail_mode) |-> channel_on_signal[NCH-1:NCH-2] == 2'b00)
    else $error("channels five or six on in fail mode");
  chk_fail_no_pwm: assert property (
    ($past(fail_mode) && $stable(channel_on_signal))[*3]
    |-> channel_drive == channel_on_signal[NCH-2:0] && !external_switch_output)
    else $error("drive modulated in fail mode");
  chk_oc_normal_rise: assert property (
    !$past(fail_mode) && !$past(fail_mode, 2)
    |-> oc_window_start == (channel_on_signal[NCH-2:0] & ~$past(channel_on_signal[NCH-2:0])))
    else $error("window start not tied to channel rising");
  chk_oc_fail_input: assert property (
    $past(fail_mode) && $past(fail_mode, 2)
    |-> oc_window_start == {1'b0, channel_on_signal[3:0] & ~$past(channel_on_signal[3:0])})
    else $error("fail window start not tied to input rising");
  chk_upper_serial_only: assert property (
    !$past(fail_mode) && !$past(fail_mode, 2) && !$past(pready) && !$past(pready, 2)
    |-> $stable(channel_on_signal[NCH-1:NCH-2]))
    else $error("channel five or six moved without a write");

  cover property (oc_window_start[0]);
  cover property (fail_mode && channel_on_signal[0]);
  cover property (pready && pslverr);
endmodule : psc_top_props

bind psc_top psc_top_props #(.NCH(NCH)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .fail_mode(fail_mode),
  .channel_on_signal(channel_on_signal), .channel_drive(channel_drive),
  .external_switch_output(external_switch_output), .oc_window_start(oc_window_start)
);

// file: sim/pulse_skip_and_input_channel_control_test.sv
// Self-checking bench for pulse skip and channel source selection
`timescale 1ns/1ps
`include "psc_defines.svh"

module pulse_skip_and_input_channel_control_test;
  import psc_pkg::*;
  // Drive high counts and longest low runs over eight skip states
  localparam int EXP_HI[6]  = '{6*256+2*248, 8*254, 8*6, 6*256+2*248, 8*1, 8*254};
  localparam int EXP_RUN[6] = '{8, 2, 250, 8, 255, 2};
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        fail_mode = 1'b0;
  logic [3:0]  din     = 4'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, pwm_clk_in, ext_out, wake;
  logic [5:0]  ch_on;
  logic [4:0]  drv, oc_start;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          cycles      = 0;

  always #5 pclk = ~pclk;

  psc_pwm_host #(.HALF(4)) i_host (.pclk(pclk), .pwm_clk_in(pwm_clk_in));

  psc_top #(.DEGLITCH_CYCLES(4), .CLK_FAIL_CYCLES(50)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fail_mode(fail_mode), .pwm_clk_in(pwm_clk_in), .direct_control_input(din),
    .channel_on_signal(ch_on), .channel_drive(drv), .external_switch_output(ext_out),
    .oc_window_start(oc_start), .wake_request(wake)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(what, exp, r);
  endtask : rdc

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    logic [31:0] r;
    logic        e;
    rdc("outctl reset", `PSC_ADDR_OUTCTL, 32'h0000_0000);
    rdc("insel reset", `PSC_ADDR_INSEL, 32'h0000_0000);
    wr(`PSC_ADDR_OUTCTL, 32'h0000_1F3F);
    rdc("outctl skip and on", `PSC_ADDR_OUTCTL, 32'h0000_1F3F);
    apb(1'b0, 12'h02C, 32'h0000_0000, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
  endtask : test_regs

  task automatic test_sel();
    logic [1:0] s;
    logic       v;
    logic       e;
    wr(`PSC_ADDR_OUTCTL, 32'h0000_003F);
    for (int k = 0; k < 8; k++) begin
      s = k[2:1];
      v = k[0];
      wr(`PSC_ADDR_INSEL, {24'h0, s, s, s, s});
      din <= {4{v}};
      repeat (12) @(posedge pclk);
      e = (s == PSC_SEL_SERIAL || s == PSC_SEL_SERIAL_SWAP || v);
      chk("channel source", {26'h0, 2'b11, {4{e}}}, {26'h0, ch_on});
      chk("wake", {31'h0, v}, {31'h0, wake});
    end
    wr(`PSC_ADDR_INSEL, 32'h0000_0055);
    din <= 4'h0;
    repeat (12) @(posedge pclk);
    din <= 4'hF;
    repeat (2) @(posedge pclk);
    din <= 4'h0;
    repeat (12) @(posedge pclk);
    chk("short pulse blocked", 32'h30, {26'h0, ch_on});
  endtask : test_sel

  task automatic test_skip();
    int          hi[6];
    int          run[6];
    int          mx[6];
    logic [5:0]  smp;
    wr(`PSC_ADDR_INSEL, 32'h0000_0000);
    wr(`PSC_ADDR_OUTCTL, 32'h0000_0D3F);
    wr(`PSC_ADDR_DUTY_FIRST, 32'h0000_00FD);
    wr(`PSC_ADDR_DUTY_FIRST + 12'h004, 32'h0000_00FD);
    wr(`PSC_ADDR_DUTY_FIRST + 12'h008, 32'h0000_0005);
    wr(`PSC_ADDR_DUTY_FIRST + 12'h014, 32'h0000_00FD);
    wr(`PSC_ADDR_GDUTY, 32'h0000_00FD);
    wr(`PSC_ADDR_GSEL, 32'h0000_0008);
    repeat (512) @(posedge pwm_clk_in);
    for (int i = 0; i < 6; i++) begin
      hi[i] = 0;
      run[i] = 0;
      mx[i] = 0;
    end
    repeat (2048) begin
      @(posedge pwm_clk_in);
      @(negedge pclk);
      smp = {ext_out, drv};
      for (int i = 0; i < 6; i++) begin
        if (smp[i]) begin
          hi[i]++;
          run[i] = 0;
        end else begin
          run[i]++;
          mx[i] = (run[i] > mx[i]) ? run[i] : mx[i];
        end
      end
    end
    for (int i = 0; i < 6; i++) begin
      chk($sformatf("drive %0d high count", i), EXP_HI[i], hi[i]);
      chk($sformatf("drive %0d low run", i), EXP_RUN[i], mx[i]);
    end
  endtask : test_skip

  task automatic test_fail();
    logic [4:0] seen;
    @(posedge pclk);
    din <= 4'h5;
    fail_mode <= 1'b1;
    seen = 5'h00;
    repeat (12) begin
      @(posedge pclk);
      seen |= oc_start;
    end
    chk("fail channels", 32'h05, {26'h0, ch_on});
    chk("fail drive", 32'h05, {26'h0, ext_out, drv});
    chk("fail window start", 32'h05, {27'h0, seen});
    din <= 4'hF;
    seen = 5'h00;
    repeat (12) begin
      @(posedge pclk);
      seen |= oc_start;
    end
    chk("fail inputs rise", 32'h0F, {26'h0, ch_on});
    chk("fail window rise", 32'h0A, {27'h0, seen});
    fail_mode <= 1'b0;
    din <= 4'h0;
    seen = 5'h00;
    repeat (4) begin
      @(posedge pclk);
      seen |= oc_start;
    end
    chk("normal window start", 32'h10, {27'h0, seen});
  endtask : test_fail

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_sel();
    test_skip();
    test_fail();
    summarize();
  end
endmodule : pulse_skip_and_input_channel_control_test
